// *** ccs_defines.svh ***
`ifndef CCS_DEFINES_SVH
`define CCS_DEFINES_SVH

`define CCS_CLK_PERIOD_PS  8000
`define CCS_AMP_HOLD_NS    5000
`define CCS_AMP_HOLD_CYC   ((`CCS_AMP_HOLD_NS * 1000 + `CCS_CLK_PERIOD_PS - 1) / `CCS_CLK_PERIOD_PS)
`define CCS_DIV_BASE_WAIT  16
`define CCS_DIV_MAX        3'h4
`define CCS_CNT_W          10
`define CCS_DIV_RESET      3'h0
`define CCS_FRH_KHZ        16000
`define CCS_FXH_KHZ        12000

`endif

// *** ccs_pkg.sv ***
package ccs_pkg;
    typedef enum logic [3:0] {
        ST_RUN      = 4'b0001,
        ST_DIV_WAIT = 4'b0010,
        ST_SRC_WAIT = 4'b0100,
        ST_AMP_HOLD = 4'b1000
    } ccs_state_t;
endpackage : ccs_pkg

// *** ccs_tick_div.sv ***
`timescale 1ns/1ps
`include "ccs_defines.svh"

// Divides the main tick stream by 2**div_sel; new ratio only at period end
module ccs_tick_div
    import ccs_pkg::*;
#(
    parameter int DW = 3
) (
    // Clock and reset
    input  wire logic          ref_clk,
    input  wire logic          rst,
    // Tick in and ratio
    input  wire logic          in_tick,
    input  wire logic [DW-1:0] div_sel,
    // Divided tick
    output logic               tick_q
);
    logic [15:0]   cnt_q;
    logic [DW-1:0] cur_q;
    logic [15:0]   mask;
    logic          wrap;

    // Period end decode; ratio adopted only here
    assign mask = 16'(16'h0001 << cur_q) - 16'h0001;
    assign wrap = in_tick && (cnt_q == mask);

    // Counter and ratio latch
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt_q  <= 16'h0000;
            cur_q  <= DW'(`CCS_DIV_RESET);
            tick_q <= 1'b0;
        end else begin
            tick_q <= wrap;
            if (wrap) begin
                cnt_q <= 16'h0000;
                cur_q <= div_sel;
            end else if (in_tick) begin
                cnt_q <= cnt_q + 16'h0001;
            end
        end
    end
endmodule : ccs_tick_div

// *** ccs_clock_switch.sv ***
`timescale 1ns/1ps
`include "ccs_defines.svh"

module ccs_clock_switch
    import ccs_pkg::*;
#(
    parameter int FRH_KHZ = `CCS_FRH_KHZ,
    parameter int FXH_KHZ = `CCS_FXH_KHZ
) (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // Source clock ticks, one cycle each
    input  wire logic       int_osc_tick,
    input  wire logic       crystal_osc_tick,
    input  wire logic       ext_clk_tick,
    // Oscillator control bits
    input  wire logic       main_osc_halt,
    input  wire logic       osc_pin_select,
    input  wire logic       ext_input_select,
    input  wire logic       int_osc_halt,
    // Gain-high write strobe and data
    input  wire logic       amp_wr,
    input  wire logic       amp_gain_high,
    // Processor clock control write
    input  wire logic       pcc_wr,
    input  wire logic [2:0] pcc_wdata,
    // Main clock mode write
    input  wire logic       mcm_wr,
    input  wire logic       main_source_select,
    input  wire logic       hs_clock_route,
    // CPU clock and status
    output logic            cpu_clk_tick_q,
    output logic            main_source_status_q,
    output logic            hs_clock_route_q,
    output logic [2:0]      cpu_div_q,
    output logic            int_osc_run_q,
    output logic            main_osc_run_q,
    output logic            cpu_held_q,
    output logic            switch_busy_q
);
    localparam int CW = `CCS_CNT_W;
    // Integer division drops the fraction
    localparam logic [CW-1:0] SRC_WAIT_R2X = CW'(1 + (2 * FRH_KHZ) / FXH_KHZ);
    localparam logic [CW-1:0] SRC_WAIT_X2R = CW'(1 + (2 * FXH_KHZ) / FRH_KHZ);
    localparam logic [CW-1:0] AMP_WAIT     = CW'(`CCS_AMP_HOLD_CYC);

    ccs_state_t    state_q, state_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic [CW-1:0] target_q, target_d;
    logic [2:0]    pend_div_q;
    logic          route_done_q;
    logic          hs_tick, main_tick, div_tick;
    logic          div_req, src_req, amp_req, route_req;
    logic          cnt_tick, cnt_end;
    logic [CW-1:0] div_wait;

    // High-speed clock is crystal or external pin
    assign hs_tick   = main_osc_run_q && osc_pin_select &&
                       (ext_input_select ? ext_clk_tick : crystal_osc_tick);
    // Main clock: 0 internal, 1 high-speed
    assign main_tick = main_source_status_q ? hs_tick
                                            : (int_osc_run_q && int_osc_tick);

    // Write decodes; all but the route write accepted only when idle
    assign amp_req   = amp_wr && amp_gain_high && (state_q == ST_RUN);
    assign div_req   = pcc_wr && (pcc_wdata <= `CCS_DIV_MAX) &&
                       (pcc_wdata != cpu_div_q) && (state_q == ST_RUN);
    assign src_req   = mcm_wr && (main_source_select != main_source_status_q) &&
                       (state_q == ST_RUN);
    assign route_req = mcm_wr && !route_done_q &&
                       (hs_clock_route != hs_clock_route_q);
    assign div_wait  = CW'(`CCS_DIV_BASE_WAIT >> cpu_div_q);

    // Counting unit differs per waiting state
    assign cnt_tick = (state_q == ST_DIV_WAIT) ? div_tick :
                      (state_q == ST_SRC_WAIT) ? main_tick :
                      (state_q == ST_AMP_HOLD);
    assign cnt_end  = cnt_tick && (cnt_q + CW'(1) == target_q);

    // Glitch-free divider
    ccs_tick_div #(.DW(3)) u_div (
        .ref_clk (ref_clk),
        .rst     (rst),
        .in_tick (main_tick),
        .div_sel (cpu_div_q),
        .tick_q  (div_tick)
    );

    // Next state
    always_comb begin
        state_d  = state_q;
        cnt_d    = cnt_tick ? cnt_q + CW'(1) : cnt_q;
        target_d = target_q;
        case (state_q)
            ST_RUN: begin
                cnt_d = '0;
                if (amp_req) begin
                    state_d  = ST_AMP_HOLD;
                    target_d = AMP_WAIT;
                end else if (div_req) begin
                    state_d  = ST_DIV_WAIT;
                    target_d = div_wait;
                end else if (src_req) begin
                    state_d  = ST_SRC_WAIT;
                    target_d = main_source_status_q ? SRC_WAIT_X2R : SRC_WAIT_R2X;
                end
            end
            ST_DIV_WAIT, ST_SRC_WAIT, ST_AMP_HOLD: begin
                if (cnt_end) begin
                    state_d = ST_RUN;
                end
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end

    // Control state
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q  <= ST_RUN;
            cnt_q    <= '0;
            target_q <= '0;
        end else begin
            state_q  <= state_d;
            cnt_q    <= cnt_d;
            target_q <= target_d;
        end
    end

    // Pending divider and its late adoption
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pend_div_q <= `CCS_DIV_RESET;
            cpu_div_q  <= `CCS_DIV_RESET;
        end else begin
            if (div_req) begin
                pend_div_q <= pcc_wdata;
            end
            if (state_q == ST_DIV_WAIT && cnt_end) begin
                cpu_div_q <= pend_div_q;
            end
        end
    end

    // Source status flips only at switchover end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            main_source_status_q <= 1'b0;
        end else if (state_q == ST_SRC_WAIT && cnt_end) begin
            main_source_status_q <= ~main_source_status_q;
        end
    end

    // Route bit: one change per reset release
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            hs_clock_route_q <= 1'b0;
            route_done_q     <= 1'b0;
        end else if (route_req) begin
            hs_clock_route_q <= hs_clock_route;
            route_done_q     <= 1'b1;
        end
    end

    // Oscillator halts honoured only off the running source
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            int_osc_run_q  <= 1'b1;
            main_osc_run_q <= 1'b0;
        end else begin
            if (!int_osc_halt) begin
                int_osc_run_q <= 1'b1;
            end else if (main_source_status_q && state_q != ST_SRC_WAIT) begin
                int_osc_run_q <= 1'b0;
            end
            if (!main_osc_halt) begin
                main_osc_run_q <= 1'b1;
            end else if (!main_source_status_q && state_q != ST_SRC_WAIT) begin
                main_osc_run_q <= 1'b0;
            end
        end
    end

    // CPU tick gated during gain hold
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cpu_clk_tick_q <= 1'b0;
            cpu_held_q     <= 1'b0;
            switch_busy_q  <= 1'b0;
        end else begin
            cpu_clk_tick_q <= div_tick && (state_q != ST_AMP_HOLD);
            cpu_held_q     <= (state_d == ST_AMP_HOLD);
            switch_busy_q  <= (state_d != ST_RUN);
        end
    end

    // Checks
    sequence s_amp_start;
        state_q == ST_RUN && amp_req;
    endsequence

    sequence s_div_start;
        state_q == ST_RUN && div_req && !amp_req;
    endsequence

    chk_amp_hold_len: assert property (@(posedge ref_clk) disable iff (rst)
        s_amp_start |=> (state_q == ST_AMP_HOLD)[*8])
        else $error("gain hold ended too early");

    chk_amp_no_tick: assert property (@(posedge ref_clk) disable iff (rst)
        state_q == ST_AMP_HOLD |=> !cpu_clk_tick_q)
        else $error("cpu tick during gain hold");

    chk_amp_target: assert property (@(posedge ref_clk) disable iff (rst)
        s_amp_start |=> target_q == AMP_WAIT)
        else $error("gain hold length wrong");

    chk_div_target: assert property (@(posedge ref_clk) disable iff (rst)
        s_div_start |=> target_q == CW'(16 >> $past(cpu_div_q)))
        else $error("divider wait count wrong");

    chk_div_stable: assert property (@(posedge ref_clk) disable iff (rst)
        state_q != ST_DIV_WAIT |=> $stable(cpu_div_q))
        else $error("divider changed outside wait");

    chk_src_stable: assert property (@(posedge ref_clk) disable iff (rst)
        state_q != ST_SRC_WAIT |=> $stable(main_source_status_q))
        else $error("status moved without switchover");

    chk_src_count: assert property (@(posedge ref_clk) disable iff (rst)
        (state_q == ST_SRC_WAIT && cnt_end) |=> $changed(main_source_status_q))
        else $error("switchover did not complete");

    chk_route_once: assert property (@(posedge ref_clk) disable iff (rst)
        route_done_q |=> $stable(hs_clock_route_q))
        else $error("route bit changed twice");

    chk_int_halt_ok: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(int_osc_run_q) |-> $past(main_source_status_q))
        else $error("internal osc halted while in use");

    chk_main_halt_ok: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(main_osc_run_q) |-> !$past(main_source_status_q))
        else $error("main osc halted while in use");
endmodule : ccs_clock_switch

// *** ccs_clock_switch_tb.sv ***
`timescale 1ns/1ps
`include "ccs_defines.svh"

module ccs_clock_switch_tb import ccs_pkg::*;;
    logic       ref_clk, rst, int_osc_tick, crystal_osc_tick, ext_clk_tick;
    logic       main_osc_halt, osc_pin_select, ext_input_select, int_osc_halt;
    logic       amp_wr, amp_gain_high, pcc_wr, mcm_wr, main_source_select, hs_clock_route;
    logic [2:0] pcc_wdata, cpu_div_q;
    logic       cpu_clk_tick_q, main_source_status_q, hs_clock_route_q;
    logic       int_osc_run_q, main_osc_run_q, cpu_held_q, switch_busy_q;
    logic [1:0] ph_q;
    int         errors, n_compared, n, t, i;

    ccs_clock_switch dut (
        .ref_clk(ref_clk), .rst(rst), .int_osc_tick(int_osc_tick),
        .crystal_osc_tick(crystal_osc_tick), .ext_clk_tick(ext_clk_tick),
        .main_osc_halt(main_osc_halt), .osc_pin_select(osc_pin_select),
        .ext_input_select(ext_input_select), .int_osc_halt(int_osc_halt),
        .amp_wr(amp_wr), .amp_gain_high(amp_gain_high), .pcc_wr(pcc_wr),
        .pcc_wdata(pcc_wdata), .mcm_wr(mcm_wr), .main_source_select(main_source_select),
        .hs_clock_route(hs_clock_route), .cpu_clk_tick_q(cpu_clk_tick_q),
        .main_source_status_q(main_source_status_q), .hs_clock_route_q(hs_clock_route_q),
        .cpu_div_q(cpu_div_q), .int_osc_run_q(int_osc_run_q),
        .main_osc_run_q(main_osc_run_q), .cpu_held_q(cpu_held_q),
        .switch_busy_q(switch_busy_q)
    );

    // Clock and source ticks, one tick every four cycles per source
    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        #1 ph_q = ph_q + 2'h1;
    end
    // Oscillator pins carry either the crystal or the external input, never both
    assign int_osc_tick     = (ph_q == 2'h0);
    assign ext_clk_tick     = (ph_q == 2'h1) && ext_input_select;
    assign crystal_osc_tick = (ph_q == 2'h2) && !ext_input_select;

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            errors++;
            $display("[ERR] %s expected %0h seen %0h", nm, e, s);
        end
    endtask : chk

    // One write pulse: 0 gain, 1 divider, 2 main clock mode
    task automatic wr(input int k, input logic [2:0] d);
        @(posedge ref_clk);
        #1;
        amp_gain_high = d[0];
        pcc_wdata = d;
        main_source_select = d[0];
        hs_clock_route = d[1];
        amp_wr = (k == 0);
        pcc_wr = (k == 1);
        mcm_wr = (k == 2);
        @(posedge ref_clk);
        #1;
        amp_wr = 1'b0;
        pcc_wr = 1'b0;
        mcm_wr = 1'b0;
    endtask : wr

    // Counts events of one kind while a wait is in progress; tk counts CPU ticks.
    // CPU tick output lags the counted tick by one cycle: its window opens one
    // cycle late and closes on the first idle cycle
    task automatic cnt(input int sel, output int c, output int tk);
        logic b;
        logic busy;
        c = 0;
        tk = 0;
        for (int k = 0; k < 3000; k++) begin
            @(negedge ref_clk);
            busy = (switch_busy_q === 1'b1);
            case (sel)
                1: b = int_osc_tick;
                2: b = crystal_osc_tick;
                3: b = cpu_held_q;
                4: b = ext_clk_tick;
                default: b = cpu_clk_tick_q;
            endcase
            if (sel == 0) begin
                c += (k > 0 && b === 1'b1);
            end else if (busy) begin
                c += (b === 1'b1);
            end
            if (k > 0) begin
                tk += (cpu_clk_tick_q === 1'b1);
            end
            if (!busy) break;
        end
        // Resume driving just after a rising edge
        @(posedge ref_clk);
        #1;
    endtask : cnt

    task automatic results;
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results

    // Watchdog
    initial begin
        #400000;
        errors++;
        results();
    end

    initial begin
        {ref_clk, amp_wr, amp_gain_high, pcc_wr, mcm_wr, main_source_select} = '0;
        {hs_clock_route, pcc_wdata, osc_pin_select, ext_input_select, int_osc_halt} = '0;
        {errors, n_compared, ph_q} = '0;
        main_osc_halt = 1'b1;
        rst = 1'b1;
        repeat (12) @(posedge ref_clk);
        #1 rst = 1'b0;
        chk("status", main_source_status_q, 0);
        chk("route", hs_clock_route_q, 0);
        chk("div", cpu_div_q, 0);
        chk("int_run", int_osc_run_q, 1);
        chk("busy", switch_busy_q, 0);
        // Crystal readied; internal halt refused while on internal clock
        main_osc_halt = 1'b0;
        osc_pin_select = 1'b1;
        int_osc_halt = 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        chk("int_run", int_osc_run_q, 1);
        chk("main_run", main_osc_run_q, 1);
        int_osc_halt = 1'b0;
        // Divider walk 0,1,2,3,4,0: wait is 16 >> old setting
        for (i = 0; i < 5; i++) begin
            wr(1, 3'((i + 1) % 5));
            cnt(0, n, t);
            chk("div_wait", n, 16 >> i);
            chk("div", cpu_div_q, (i + 1) % 5);
        end
        wr(1, 3'h5);
        chk("busy", switch_busy_q, 0);
        chk("div", cpu_div_q, 0);
        // Gain high holds CPU clock for 5 us
        wr(0, 3'h1);
        cnt(3, n, t);
        chk("held", n, `CCS_AMP_HOLD_CYC);
        chk("cpu_ticks", t, 0);
        chk("held_end", cpu_held_q, 0);
        // Route set, then switch to high-speed clock
        wr(2, 3'h2);
        chk("route", hs_clock_route_q, 1);
        chk("status", main_source_status_q, 0);
        wr(2, 3'h3);
        cnt(1, n, t);
        chk("to_hs", n, 1 + (2 * 16000) / 12000);
        chk("status", main_source_status_q, 1);
        wr(2, 3'h1);
        chk("route", hs_clock_route_q, 1);
        // Internal halt allowed, main halt refused on high-speed clock
        int_osc_halt = 1'b1;
        main_osc_halt = 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        chk("int_run", int_osc_run_q, 0);
        chk("main_run", main_osc_run_q, 1);
        int_osc_halt = 1'b0;
        main_osc_halt = 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        chk("int_run", int_osc_run_q, 1);
        // Back to internal oscillator, then main halt allowed
        wr(2, 3'h0);
        cnt(2, n, t);
        chk("to_int", n, 1 + (2 * 12000) / 16000);
        chk("status", main_source_status_q, 0);
        chk("route", hs_clock_route_q, 1);
        main_osc_halt = 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        chk("main_run", main_osc_run_q, 0);
        // External input in place of the crystal, then back to internal
        ext_input_select = 1'b1;
        main_osc_halt = 1'b0;
        wr(2, 3'h1);
        cnt(1, n, t);
        chk("to_ext", n, 1 + (2 * `CCS_FRH_KHZ) / `CCS_FXH_KHZ);
        chk("status", main_source_status_q, 1);
        wr(2, 3'h0);
        cnt(4, n, t);
        chk("from_ext", n, 1 + (2 * `CCS_FXH_KHZ) / `CCS_FRH_KHZ);
        chk("status", main_source_status_q, 0);
        results();
    end
endmodule : ccs_clock_switch_tb
